/* pkg/ris_pkg.sv */
//------------------------------------------------------------
// Overview of operation
// R1: selector writes only while lock bit clear
// R2: six-bit fields pick numbered remappable pin
// R3: reg zero ext irq one in 13-8
// R4: reg one irq three high, two low
// R5: reg two ext irq four in 5-0
// R6: reg three timer three high, two low
// R7: reg four timer five high, four low
// R8: reg seven capture two high, one low
// R9: reg eight capture four high, three low
// R10: reg nine capture six high, five low
// R11: reg ten capture seven in 5-0
// R12: reg eleven fault b high, a low
// R13: reg seventeen serial three rx high
// R14: reg eighteen serial one cts high, rx low
// R15: reg nineteen serial two cts high, rx low
// R16: unimplemented bits read zero, ignore writes
// R17: reset fields all ones, lock clear
// R18: selector above last pin gives no pin
// R19: software runs two-key unlock sequence
// R20: selection live, new value next cycle
//------------------------------------------------------------
package ris_pkg;

  //------------------------------------------------------------
  // sizes
  //------------------------------------------------------------
  localparam int unsigned RIS_SEL_W = 6;
  localparam int unsigned RIS_NUM_SEL = 22;
  localparam int unsigned RIS_NUM_PINS = 44;
  localparam int unsigned RIS_NUM_REGS = 13;

  //------------------------------------------------------------
  // register byte offsets (register index times four)
  //------------------------------------------------------------
  localparam logic [11:0] RIS_OFS_IRQ_ONE = 12'h000;
  localparam logic [11:0] RIS_OFS_IRQ_TWO_THREE = 12'h004;
  localparam logic [11:0] RIS_OFS_IRQ_FOUR = 12'h008;
  localparam logic [11:0] RIS_OFS_TMR_TWO_THREE = 12'h00c;
  localparam logic [11:0] RIS_OFS_TMR_FOUR_FIVE = 12'h010;
  localparam logic [11:0] RIS_OFS_CAP_ONE_TWO = 12'h01c;
  localparam logic [11:0] RIS_OFS_CAP_THREE_FOUR = 12'h020;
  localparam logic [11:0] RIS_OFS_CAP_FIVE_SIX = 12'h024;
  localparam logic [11:0] RIS_OFS_CAP_SEVEN = 12'h028;
  localparam logic [11:0] RIS_OFS_CMP_FAULTS = 12'h02c;
  localparam logic [11:0] RIS_OFS_SER_THREE_RX = 12'h044;
  localparam logic [11:0] RIS_OFS_SER_ONE = 12'h048;
  localparam logic [11:0] RIS_OFS_SER_TWO = 12'h04c;
  localparam logic [11:0] RIS_OFS_LOCK = 12'h100;

  //------------------------------------------------------------
  // field positions and reset values
  //------------------------------------------------------------
  localparam int unsigned RIS_HI_LSB = 8;
  localparam int unsigned RIS_LO_LSB = 0;
  localparam int unsigned RIS_LOCK_BIT = 6;
  localparam logic [5:0] RIS_SEL_RST = 6'h3f;
  localparam logic [5:0] RIS_SEL_MAX = 6'h2b;
  localparam logic RIS_LOCK_RST = 1'b0;

  // peripheral inputs routed by the bank
  typedef struct packed {
    logic ext_irq_one_input;
    logic ext_irq_two_input;
    logic ext_irq_three_input;
    logic ext_irq_four_input;
    logic timer_two_ext_clock;
    logic timer_three_ext_clock;
    logic timer_four_ext_clock;
    logic timer_five_ext_clock;
    logic [6:0] capture_input;
    logic compare_fault_a_input;
    logic compare_fault_b_input;
    logic serial_one_receive;
    logic serial_one_clear_to_send;
    logic serial_two_receive;
    logic serial_two_clear_to_send;
    logic serial_three_receive;
  } ris_periph_s;

  // apb request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ris_apb_req_s;

endpackage

/* core/ris_input_select.sv */
`timescale 1ns/1ps
module ris_input_select (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire ris_pkg::ris_apb_req_s apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins and peripherals
  input wire logic [ris_pkg::RIS_NUM_PINS-1:0] remappable_pin,
  output ris_pkg::ris_periph_s periph,
  output logic remap_lock_bit
);
  import ris_pkg::*;

  //------------------------------------------------------------
  // selector storage, index order follows periph struct order
  //------------------------------------------------------------
  // 0..3 irq one..four, 4..7 timer two..five, 8..14 capture one..seven,
  // 15 fault a, 16 fault b, 17 ser1 rx, 18 ser1 cts, 19 ser2 rx,
  // 20 ser2 cts, 21 ser3 rx
  logic [RIS_SEL_W-1:0] sel [RIS_NUM_SEL];
  logic wr_en;
  logic rd_en;
  logic [31:0] next_rdata;
  logic addr_hit;
  logic [31:0] wd;
  logic [RIS_NUM_SEL-1:0] routed;

  assign wd = apb_req.pwdata;
  // writes land on the access phase only, one-cycle answer
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & ~pready;
  assign rd_en = apb_req.psel & apb_req.penable & ~apb_req.pwrite & ~pready;

  // pready pulses on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_req.psel & apb_req.penable & ~pready;
    end
  end

  // error flag for unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= apb_req.psel & apb_req.penable & ~pready & ~addr_hit;
    end
  end

  //------------------------------------------------------------
  // lock bit, software owns the unlock keys upstream
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remap_lock_bit <= RIS_LOCK_RST; // R17
    end else if (wr_en && apb_req.paddr == RIS_OFS_LOCK) begin
      remap_lock_bit <= wd[RIS_LOCK_BIT]; // R19
    end
  end

  //------------------------------------------------------------
  // selector writes; locked writes complete but change nothing
  //------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < RIS_NUM_SEL; i++) begin
        sel[i] <= RIS_SEL_RST; // R17
      end
    end else if (wr_en && !remap_lock_bit) begin // R1
      // upper bits 15-14 and 7-6 never stored: R16
      case (apb_req.paddr)
        RIS_OFS_IRQ_ONE: sel[0] <= wd[RIS_HI_LSB +: RIS_SEL_W]; // R3
        RIS_OFS_IRQ_TWO_THREE: begin // R4
          sel[1] <= wd[RIS_LO_LSB +: RIS_SEL_W];
          sel[2] <= wd[RIS_HI_LSB +: RIS_SEL_W];
        end
        RIS_OFS_IRQ_FOUR: sel[3] <= wd[RIS_LO_LSB +: RIS_SEL_W]; // R5
        RIS_OFS_TMR_TWO_THREE: begin // R6
          sel[4] <= wd[RIS_LO_LSB +: RIS_SEL_W];
          sel[5] <= wd[RIS_HI_LSB +: RIS_SEL_W];
        end
        RIS_OFS_TMR_FOUR_FIVE: begin // R7
          sel[6] <= wd[RIS_LO_LSB +: RIS_SEL_W];
          sel[7] <= wd[RIS_HI_LSB +: RIS_SEL_W];
        end
        RIS_OFS_CAP_ONE_TWO: begin // R8
          sel[8] <= wd[RIS_LO_LSB +: RIS_SEL_W];
          sel[9] <= wd[RIS_HI_LSB +: RIS_SEL_W];
        end
        RIS_OFS_CAP_THREE_FOUR: begin // R9
          sel[10] <= wd[RIS_LO_LSB +: RIS_SEL_W];
          sel[11] <= wd[RIS_HI_LSB +: RIS_SEL_W];
        end
        RIS_OFS_CAP_FIVE_SIX: begin // R10
          sel[12] <= wd[RIS_LO_LSB +: RIS_SEL_W];
          sel[13] <= wd[RIS_HI_LSB +: RIS_SEL_W];
        end
        RIS_OFS_CAP_SEVEN: sel[14] <= wd[RIS_LO_LSB +: RIS_SEL_W]; // R11
        RIS_OFS_CMP_FAULTS: begin // R12
          sel[15] <= wd[RIS_LO_LSB +: RIS_SEL_W];
          sel[16] <= wd[RIS_HI_LSB +: RIS_SEL_W];
        end
        RIS_OFS_SER_ONE: begin // R14
          sel[17] <= wd[RIS_LO_LSB +: RIS_SEL_W];
          sel[18] <= wd[RIS_HI_LSB +: RIS_SEL_W];
        end
        RIS_OFS_SER_TWO: begin // R15
          sel[19] <= wd[RIS_LO_LSB +: RIS_SEL_W];
          sel[20] <= wd[RIS_HI_LSB +: RIS_SEL_W];
        end
        RIS_OFS_SER_THREE_RX: sel[21] <= wd[RIS_HI_LSB +: RIS_SEL_W]; // R13
        default: ;
      endcase
    end
  end

  //------------------------------------------------------------
  // read mux, unimplemented positions stay zero
  //------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    addr_hit = 1'b1;
    case (apb_req.paddr)
      RIS_OFS_IRQ_ONE: next_rdata[13:8] = sel[0]; // R16
      RIS_OFS_IRQ_TWO_THREE: next_rdata[13:0] = {sel[2], 2'b00, sel[1]};
      RIS_OFS_IRQ_FOUR: next_rdata[5:0] = sel[3];
      RIS_OFS_TMR_TWO_THREE: next_rdata[13:0] = {sel[5], 2'b00, sel[4]};
      RIS_OFS_TMR_FOUR_FIVE: next_rdata[13:0] = {sel[7], 2'b00, sel[6]};
      RIS_OFS_CAP_ONE_TWO: next_rdata[13:0] = {sel[9], 2'b00, sel[8]};
      RIS_OFS_CAP_THREE_FOUR: next_rdata[13:0] = {sel[11], 2'b00, sel[10]};
      RIS_OFS_CAP_FIVE_SIX: next_rdata[13:0] = {sel[13], 2'b00, sel[12]};
      RIS_OFS_CAP_SEVEN: next_rdata[5:0] = sel[14];
      RIS_OFS_CMP_FAULTS: next_rdata[13:0] = {sel[16], 2'b00, sel[15]};
      RIS_OFS_SER_THREE_RX: next_rdata[13:8] = sel[21];
      RIS_OFS_SER_ONE: next_rdata[13:0] = {sel[18], 2'b00, sel[17]};
      RIS_OFS_SER_TWO: next_rdata[13:0] = {sel[20], 2'b00, sel[19]};
      RIS_OFS_LOCK: next_rdata[RIS_LOCK_BIT] = remap_lock_bit;
      default: addr_hit = 1'b0;
    endcase
  end

  // read data registered with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= next_rdata;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  //------------------------------------------------------------
  // routing: invalid codes (above last pin, incl. reset 63) give 0
  //------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < RIS_NUM_SEL; i++) begin
      routed[i] = (sel[i] <= RIS_SEL_MAX) ? remappable_pin[sel[i]] : 1'b0; // R2 R18
    end
  end

  // outputs registered, so a new selector shows one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph <= '0;
    end else begin
      periph.ext_irq_one_input <= routed[0]; // R20
      periph.ext_irq_two_input <= routed[1];
      periph.ext_irq_three_input <= routed[2];
      periph.ext_irq_four_input <= routed[3];
      periph.timer_two_ext_clock <= routed[4];
      periph.timer_three_ext_clock <= routed[5];
      periph.timer_four_ext_clock <= routed[6];
      periph.timer_five_ext_clock <= routed[7];
      periph.capture_input <= routed[14:8];
      periph.compare_fault_a_input <= routed[15];
      periph.compare_fault_b_input <= routed[16];
      periph.serial_one_receive <= routed[17];
      periph.serial_one_clear_to_send <= routed[18];
      periph.serial_two_receive <= routed[19];
      periph.serial_two_clear_to_send <= routed[20];
      periph.serial_three_receive <= routed[21];
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  sequence s_locked_write;
    wr_en && remap_lock_bit && apb_req.paddr == RIS_OFS_SER_ONE;
  endsequence

  AST_LOCK_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn) // R1
    s_locked_write |=> $stable(sel[17]) && $stable(sel[18]))
    else $error("selector changed while locked");

  AST_UNLOCKED_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // R14
    wr_en && !remap_lock_bit && apb_req.paddr == RIS_OFS_SER_ONE |=> sel[17] == $past(wd[5:0]))
    else $error("serial one rx not written");

  AST_HI_FIELD: assert property (@(posedge pclk) disable iff (!presetn) // R3
    wr_en && !remap_lock_bit && apb_req.paddr == RIS_OFS_IRQ_ONE |=> sel[0] == $past(wd[13:8]))
    else $error("irq one field wrong");

  AST_RSV_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R16
    pready |-> prdata[31:14] == 18'h0_0000 && !prdata[7] && (!prdata[6] || apb_req.paddr == RIS_OFS_LOCK))
    else $error("reserved bits not zero");

  AST_INVALID_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R18
    sel[17] > RIS_SEL_MAX |=> !periph.serial_one_receive)
    else $error("invalid code routed a pin");

  AST_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[0] <= RIS_SEL_MAX |=> periph.ext_irq_one_input == $past(remappable_pin[sel[0]]))
    else $error("routing mismatch");

  AST_READY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    apb_req.psel && apb_req.penable && !pready |=> pready ##1 !pready)
    else $error("pready not one cycle");

  AST_LOCK_SET: assert property (@(posedge pclk) disable iff (!presetn) // R19
    wr_en && apb_req.paddr == RIS_OFS_LOCK |=> remap_lock_bit == $past(wd[6]))
    else $error("lock bit not updated");

  //------------------------------------------------------------
  // per-register field landing
  //------------------------------------------------------------
  // unlocked write to one register offset
  sequence s_open_write(logic [11:0] ofs);
    wr_en && !remap_lock_bit && apb_req.paddr == ofs;
  endsequence

  AST_WR_IRQ_TWO_THREE: assert property (@(posedge pclk) disable iff (!presetn) // R4
    s_open_write(RIS_OFS_IRQ_TWO_THREE) |=> sel[1] == $past(wd[5:0]) && sel[2] == $past(wd[13:8]))
    else $error("irq two or three field wrong");

  AST_WR_IRQ_FOUR: assert property (@(posedge pclk) disable iff (!presetn) // R5
    s_open_write(RIS_OFS_IRQ_FOUR) |=> sel[3] == $past(wd[5:0]))
    else $error("irq four field wrong");

  AST_WR_TMR_TWO_THREE: assert property (@(posedge pclk) disable iff (!presetn) // R6
    s_open_write(RIS_OFS_TMR_TWO_THREE) |=> sel[4] == $past(wd[5:0]) && sel[5] == $past(wd[13:8]))
    else $error("timer two or three field wrong");

  AST_WR_TMR_FOUR_FIVE: assert property (@(posedge pclk) disable iff (!presetn) // R7
    s_open_write(RIS_OFS_TMR_FOUR_FIVE) |=> sel[6] == $past(wd[5:0]) && sel[7] == $past(wd[13:8]))
    else $error("timer four or five field wrong");

  AST_WR_CAP_ONE_TWO: assert property (@(posedge pclk) disable iff (!presetn) // R8
    s_open_write(RIS_OFS_CAP_ONE_TWO) |=> sel[8] == $past(wd[5:0]) && sel[9] == $past(wd[13:8]))
    else $error("capture one or two field wrong");

  AST_WR_CAP_THREE_FOUR: assert property (@(posedge pclk) disable iff (!presetn) // R9
    s_open_write(RIS_OFS_CAP_THREE_FOUR) |=> sel[10] == $past(wd[5:0]) && sel[11] == $past(wd[13:8]))
    else $error("capture three or four field wrong");

  AST_WR_CAP_FIVE_SIX: assert property (@(posedge pclk) disable iff (!presetn) // R10
    s_open_write(RIS_OFS_CAP_FIVE_SIX) |=> sel[12] == $past(wd[5:0]) && sel[13] == $past(wd[13:8]))
    else $error("capture five or six field wrong");

  AST_WR_CAP_SEVEN: assert property (@(posedge pclk) disable iff (!presetn) // R11
    s_open_write(RIS_OFS_CAP_SEVEN) |=> sel[14] == $past(wd[5:0]))
    else $error("capture seven field wrong");

  AST_WR_CMP_FAULTS: assert property (@(posedge pclk) disable iff (!presetn) // R12
    s_open_write(RIS_OFS_CMP_FAULTS) |=> sel[15] == $past(wd[5:0]) && sel[16] == $past(wd[13:8]))
    else $error("compare fault field wrong");

  AST_WR_SER_THREE: assert property (@(posedge pclk) disable iff (!presetn) // R13
    s_open_write(RIS_OFS_SER_THREE_RX) |=> sel[21] == $past(wd[13:8]))
    else $error("serial three rx field wrong");

  AST_WR_SER_TWO: assert property (@(posedge pclk) disable iff (!presetn) // R15
    s_open_write(RIS_OFS_SER_TWO) |=> sel[19] == $past(wd[5:0]) && sel[20] == $past(wd[13:8]))
    else $error("serial two field wrong");

  //------------------------------------------------------------
  // per-input routing; catches a crossed index in the wiring
  //------------------------------------------------------------
  AST_ROUTE_IRQ_TWO: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[1] <= RIS_SEL_MAX |=> periph.ext_irq_two_input == $past(remappable_pin[sel[1]]))
    else $error("irq two routing mismatch");

  AST_ROUTE_IRQ_THREE: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[2] <= RIS_SEL_MAX |=> periph.ext_irq_three_input == $past(remappable_pin[sel[2]]))
    else $error("irq three routing mismatch");

  AST_ROUTE_IRQ_FOUR: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[3] <= RIS_SEL_MAX |=> periph.ext_irq_four_input == $past(remappable_pin[sel[3]]))
    else $error("irq four routing mismatch");

  AST_ROUTE_TMR_TWO: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[4] <= RIS_SEL_MAX |=> periph.timer_two_ext_clock == $past(remappable_pin[sel[4]]))
    else $error("timer two routing mismatch");

  AST_ROUTE_TMR_THREE: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[5] <= RIS_SEL_MAX |=> periph.timer_three_ext_clock == $past(remappable_pin[sel[5]]))
    else $error("timer three routing mismatch");

  AST_ROUTE_TMR_FOUR: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[6] <= RIS_SEL_MAX |=> periph.timer_four_ext_clock == $past(remappable_pin[sel[6]]))
    else $error("timer four routing mismatch");

  AST_ROUTE_TMR_FIVE: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[7] <= RIS_SEL_MAX |=> periph.timer_five_ext_clock == $past(remappable_pin[sel[7]]))
    else $error("timer five routing mismatch");

  AST_ROUTE_CAP_ONE: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[8] <= RIS_SEL_MAX |=> periph.capture_input[0] == $past(remappable_pin[sel[8]]))
    else $error("capture one routing mismatch");

  AST_ROUTE_CAP_TWO: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[9] <= RIS_SEL_MAX |=> periph.capture_input[1] == $past(remappable_pin[sel[9]]))
    else $error("capture two routing mismatch");

  AST_ROUTE_CAP_THREE: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[10] <= RIS_SEL_MAX |=> periph.capture_input[2] == $past(remappable_pin[sel[10]]))
    else $error("capture three routing mismatch");

  AST_ROUTE_CAP_FOUR: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[11] <= RIS_SEL_MAX |=> periph.capture_input[3] == $past(remappable_pin[sel[11]]))
    else $error("capture four routing mismatch");

  AST_ROUTE_CAP_FIVE: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[12] <= RIS_SEL_MAX |=> periph.capture_input[4] == $past(remappable_pin[sel[12]]))
    else $error("capture five routing mismatch");

  AST_ROUTE_CAP_SIX: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[13] <= RIS_SEL_MAX |=> periph.capture_input[5] == $past(remappable_pin[sel[13]]))
    else $error("capture six routing mismatch");

  AST_ROUTE_CAP_SEVEN: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[14] <= RIS_SEL_MAX |=> periph.capture_input[6] == $past(remappable_pin[sel[14]]))
    else $error("capture seven routing mismatch");

  AST_ROUTE_FAULT_A: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[15] <= RIS_SEL_MAX |=> periph.compare_fault_a_input == $past(remappable_pin[sel[15]]))
    else $error("fault a routing mismatch");

  AST_ROUTE_FAULT_B: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[16] <= RIS_SEL_MAX |=> periph.compare_fault_b_input == $past(remappable_pin[sel[16]]))
    else $error("fault b routing mismatch");

  AST_ROUTE_SER_ONE_RX: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[17] <= RIS_SEL_MAX |=> periph.serial_one_receive == $past(remappable_pin[sel[17]]))
    else $error("serial one rx routing mismatch");

  AST_ROUTE_SER_ONE_CTS: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[18] <= RIS_SEL_MAX |=> periph.serial_one_clear_to_send == $past(remappable_pin[sel[18]]))
    else $error("serial one cts routing mismatch");

  AST_ROUTE_SER_TWO_RX: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[19] <= RIS_SEL_MAX |=> periph.serial_two_receive == $past(remappable_pin[sel[19]]))
    else $error("serial two rx routing mismatch");

  AST_ROUTE_SER_TWO_CTS: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[20] <= RIS_SEL_MAX |=> periph.serial_two_clear_to_send == $past(remappable_pin[sel[20]]))
    else $error("serial two cts routing mismatch");

  AST_ROUTE_SER_THREE_RX: assert property (@(posedge pclk) disable iff (!presetn) // R20
    sel[21] <= RIS_SEL_MAX |=> periph.serial_three_receive == $past(remappable_pin[sel[21]]))
    else $error("serial three rx routing mismatch");

  AST_INVALID_IRQ_ONE: assert property (@(posedge pclk) disable iff (!presetn) // R18
    sel[0] > RIS_SEL_MAX |=> !periph.ext_irq_one_input)
    else $error("invalid code routed irq one");

  AST_INVALID_IRQ_THREE: assert property (@(posedge pclk) disable iff (!presetn) // R18
    sel[2] > RIS_SEL_MAX |=> !periph.ext_irq_three_input)
    else $error("invalid code routed irq three");

endmodule

/* testbench/tb_remappable_input_select.sv */
`timescale 1ns/1ps
module tb_remappable_input_select;
  import ris_pkg::*;
  //------------------------------------------------------------
  // design, clock and shared state
  //------------------------------------------------------------
  logic pclk;
  logic presetn;
  ris_apb_req_s req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [RIS_NUM_PINS-1:0] pins;
  ris_periph_s periph;
  logic lock;
  int err_total;
  int samples_checked;
  logic [31:0] rd;
  logic er;
  logic [5:0] hs [13];
  logic [5:0] ls [13];
  localparam logic [11:0] OFS [13] = '{RIS_OFS_IRQ_ONE, RIS_OFS_IRQ_TWO_THREE, RIS_OFS_IRQ_FOUR,
    RIS_OFS_TMR_TWO_THREE, RIS_OFS_TMR_FOUR_FIVE, RIS_OFS_CAP_ONE_TWO, RIS_OFS_CAP_THREE_FOUR,
    RIS_OFS_CAP_FIVE_SIX, RIS_OFS_CAP_SEVEN, RIS_OFS_CMP_FAULTS, RIS_OFS_SER_THREE_RX,
    RIS_OFS_SER_ONE, RIS_OFS_SER_TWO};

  ris_input_select DUT (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .remappable_pin(pins), .periph(periph),
    .remap_lock_bit(lock));

  // free running clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  // implemented selector bits of each register in bank order
  function automatic logic [31:0] mask(input int i);
    if (i == 0 || i == 10) return 32'h0000_3f00;
    if (i == 2 || i == 8) return 32'h0000_003f;
    return 32'h0000_3f3f;
  endfunction

  // codes past the last pin route nothing
  function automatic logic pk(input logic [5:0] s);
    return (s < RIS_NUM_PINS) ? pins[s] : 1'b0;
  endfunction

  // expected peripheral bundle, packed in struct order
  function automatic logic [21:0] route();
    return {pk(hs[0]), pk(ls[1]), pk(hs[1]), pk(ls[2]), pk(ls[3]), pk(hs[3]), pk(ls[4]), pk(hs[4]),
      pk(ls[8]), pk(hs[7]), pk(ls[7]), pk(hs[6]), pk(ls[6]), pk(hs[5]), pk(ls[5]),
      pk(ls[9]), pk(hs[9]), pk(ls[11]), pk(hs[11]), pk(ls[12]), pk(hs[12]), pk(hs[10])};
  endfunction

  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer; waits on pready rather than assuming a latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    req <= '0;
    if (pready !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t bus timeout", $time);
      complete_run();
    end
  endtask

  // routed outputs settle one cycle after pins move
  task automatic chk_route(input logic [43:0] p, input string msg);
    @(posedge pclk);
    pins <= p;
    repeat (2) @(posedge pclk);
    chk({10'h0, periph}, {10'h0, route()}, msg);
  endtask

  //------------------------------------------------------------
  // scenarios
  //------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 13; i++) begin
      apb(1'b0, OFS[i], 32'h0);
      chk(rd, mask(i), "reset value");
    end
    apb(1'b0, RIS_OFS_LOCK, 32'h0);
    chk(rd, 32'h0000_0000, "lock reset");
    chk({10'h0, periph}, 32'h0, "reset routes ground");
  endtask

  task automatic t_fields();
    for (int i = 0; i < 13; i++) begin
      apb(1'b1, OFS[i], 32'hffff_eaea);
      apb(1'b0, OFS[i], 32'h0);
      chk(rd, 32'hffff_eaea & mask(i), "field layout");
    end
  endtask

  task automatic t_route();
    for (int i = 0; i < 13; i++) begin
      hs[i] = 6'(i + 20);
      ls[i] = 6'(i);
      apb(1'b1, OFS[i], {16'h0, 2'b0, hs[i], 2'b0, ls[i]});
    end
    chk_route(44'h555_5555_5555, "route odd");
    chk_route(44'haaa_aaaa_aaaa, "route even");
    chk_route(44'h0f0_f0f0_f0f0, "route nibble");
  endtask

  task automatic t_invalid();
    hs[0] = 6'h2c;
    ls[1] = 6'h2b;
    hs[1] = 6'h3f;
    apb(1'b1, OFS[0], 32'h0000_2c00);
    apb(1'b1, OFS[1], 32'h0000_3f2b);
    chk_route(44'hfff_ffff_ffff, "invalid code");
  endtask

  task automatic t_lock();
    apb(1'b1, RIS_OFS_LOCK, 32'h0000_0040);
    chk({31'h0, lock}, 32'h1, "lock pin");
    apb(1'b0, RIS_OFS_LOCK, 32'h0);
    chk(rd, 32'h0000_0040, "lock readback");
    apb(1'b1, OFS[3], 32'h0000_0000);
    apb(1'b1, OFS[11], 32'h0000_0000);
    apb(1'b0, OFS[3], 32'h0);
    chk(rd, {16'h0, 2'b0, hs[3], 2'b0, ls[3]}, "locked write ignored");
    apb(1'b0, OFS[11], 32'h0);
    chk(rd, {16'h0, 2'b0, hs[11], 2'b0, ls[11]}, "locked serial write ignored");
    chk_route(44'h333_3333_3333, "locked routing kept");
    apb(1'b1, RIS_OFS_LOCK, 32'h0000_0000);
    ls[3] = 6'h05;
    apb(1'b1, OFS[3], {16'h0, 2'b0, hs[3], 2'b0, ls[3]});
    chk_route(44'h000_0000_0020, "unlocked write");
  endtask

  task automatic t_unmapped();
    apb(1'b0, 12'h0f0, 32'h0);
    chk({er, rd}, {1'b1, 32'h0}, "unmapped read");
    apb(1'b1, 12'h0f4, 32'hffff_ffff);
    chk({31'h0, er}, 32'h1, "unmapped write");
  endtask

  // reset in mid-run with the bank locked and fields written
  task automatic t_rearm();
    apb(1'b1, RIS_OFS_LOCK, 32'h0000_0040);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
  endtask

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    err_total = 0;
    samples_checked = 0;
    presetn = 1'b0;
    req = '0;
    pins = '1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fields();
    t_route();
    t_invalid();
    t_lock();
    t_unmapped();
    t_rearm();
    complete_run();
  end
endmodule
